// file: iwt_top.sv
`default_nettype none
module iwt_top (
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  // processor bus cycle
  input  wire logic                      cycle_start_in,
  input  wire logic                      cycle_read_in,
  input  wire logic                      cycle_mem_in,
  input  wire logic [iwt_pkg::ADDR_W-1:0] addr_in,
  input  wire logic                      command_holdoff_input,
  input  wire logic                      irq_ack_in,
  input  wire logic                      cascade_mode_in,
  input  wire logic                      pclk_in,
  input  wire logic [7:0]                data_in,
  // bus answer
  output logic                           ready_out,
  output logic                           xcvr_enable_out,
  output logic [7:0]                     data_out,
  // serial controller side
  output logic                           ser_select_out,
  output logic                           register_select_low,
  output logic                           register_select_high,
  output logic                           io_read_strobe_out,
  output logic                           io_write_strobe_out,
  output logic                           irq_acknowledge_strobe,
  output logic                           ser_clk_out,
  // parallel port side
  output logic                           par_select_out
);
  import iwt_pkg::*;

  typedef struct packed {
    iwt_state_t       st;
    logic             is_ser;
    logic             is_par;
    logic             rd;
    logic             rd_strobe;
    logic             wr_strobe;
    logic             ready;
    logic             xcvr;
    logic             sel_lo;
    logic             sel_hi;
    logic [7:0]       data;
    logic             ack_pend;
    logic             ack_out;
    logic             ser_clk;
    logic [2:0]       pclk_sync;
    logic             pclk_q;
    logic [2:0]       hold_sync;
    logic             hold_q;
    logic [2:0]       ack_sync;
    logic             ack_q;
    logic [CNT_W-1:0] ser_space;
    logic [CNT_W-1:0] par_space;
  } iwt_top_t;

  // spacing counters clear so the first access after reset goes at once
  localparam iwt_top_t IWT_TOP_RST = '{
    st:        IWT_IDLE,
    is_ser:    1'b0,
    is_par:    1'b0,
    rd:        1'b0,
    rd_strobe: 1'b0,
    wr_strobe: 1'b0,
    ready:     1'b0,
    xcvr:      1'b0,
    sel_lo:    1'b0,
    sel_hi:    1'b0,
    data:      '0,
    ack_pend:  1'b0,
    ack_out:   1'b0,
    ser_clk:   1'b0,
    pclk_sync: '0,
    pclk_q:    1'b0,
    hold_sync: '0,
    hold_q:    1'b0,
    ack_sync:  '0,
    ack_q:     1'b0,
    ser_space: '0,
    par_space: '0
  };

  iwt_top_t  s_r;
  iwt_top_t  s_nxt;
  iwt_cnt_if wait_if ();
  iwt_cnt_if ack_if ();

  logic       hit_ser;
  logic       hit_par;
  logic       space_clear;
  logic [CNT_W-1:0] wait_load;
  logic [CNT_W-1:0] dly_load;

  // wait-state timer
  iwt_delay u_wait (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ctl    (wait_if)
  );
  // acknowledge delay timer
  iwt_delay u_ack (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ctl    (ack_if)
  );

  assign hit_ser = ((addr_in & SER_MASK) == SER_BASE);
  assign hit_par = ((addr_in & PAR_MASK) == PAR_BASE);
  assign space_clear = s_r.is_ser ? (s_r.ser_space == '0) : (s_r.par_space == '0);

  always_comb begin
    s_nxt               = s_r;
    wait_load           = '0;
    dly_load            = '0;
    wait_if.start       = 1'b0;
    wait_if.load        = '0;
    ack_if.start        = 1'b0;
    ack_if.load         = '0;
    s_nxt.ready         = 1'b0;
    // metastability: third stage compared against second only
    s_nxt.pclk_sync     = {s_r.pclk_sync[1:0], pclk_in};
    s_nxt.hold_sync     = {s_r.hold_sync[1:0], command_holdoff_input};
    s_nxt.ack_sync      = {s_r.ack_sync[1:0], irq_ack_in};
    if (s_r.pclk_sync[2] == s_r.pclk_sync[1]) s_nxt.pclk_q = s_r.pclk_sync[2];
    if (s_r.hold_sync[2] == s_r.hold_sync[1]) s_nxt.hold_q = s_r.hold_sync[2];
    if (s_r.ack_sync[2] == s_r.ack_sync[1]) s_nxt.ack_q = s_r.ack_sync[2];
    // divide by two on rising pclk
    if (s_nxt.pclk_q && !s_r.pclk_q) s_nxt.ser_clk = ~s_r.ser_clk;
    if (s_r.ser_space != '0) s_nxt.ser_space = s_r.ser_space - CNT_W'(1);
    if (s_r.par_space != '0) s_nxt.par_space = s_r.par_space - CNT_W'(1);
    if (s_nxt.ack_q && !s_r.ack_q) begin
      if (cascade_mode_in) begin
        ack_if.start   = 1'b1;
        ack_if.load    = CNT_W'(ACK_DELAY_CYC);
        s_nxt.ack_pend = 1'b1;
      end else begin
        s_nxt.ack_out = 1'b1;
      end
    end else if (s_r.ack_pend && ack_if.done) begin
      s_nxt.ack_out  = 1'b1;
      s_nxt.ack_pend = 1'b0;
    end
    if (!s_nxt.ack_q) begin
      s_nxt.ack_out  = 1'b0;
      s_nxt.ack_pend = 1'b0;
    end
    if (s_r.is_ser) begin
      wait_load = CNT_W'(WAIT_STATES_SER * CLK_PER_WAIT * BUS_DIV);
      dly_load  = CNT_W'(CMD_DELAY_SER * BUS_DIV);
    end else begin
      wait_load = CNT_W'(WAIT_STATES_PAR * CLK_PER_WAIT * BUS_DIV);
      dly_load  = CNT_W'(CMD_DELAY_PAR * BUS_DIV);
    end
    case (s_r.st)
      IWT_IDLE: begin
        if (cycle_start_in && (hit_ser || hit_par)) begin
          // latched selects from A1 and A2
          s_nxt.is_ser = hit_ser;
          s_nxt.is_par = hit_par && !hit_ser;
          s_nxt.rd     = cycle_read_in;
          s_nxt.sel_lo = addr_in[SEL_LOW_BIT];
          s_nxt.sel_hi = addr_in[SEL_HIGH_BIT];
          s_nxt.data   = data_in;
          s_nxt.st     = IWT_SPACE;
        end
      end
      IWT_SPACE: begin
        if (space_clear) begin
          wait_if.start = 1'b1;
          wait_if.load  = dly_load;
          s_nxt.st      = IWT_HOLD;
        end
      end
      IWT_HOLD: begin
        // command held off while delay or holdoff runs
        if (wait_if.done && !wait_if.start && !s_r.hold_q) begin
          wait_if.start = 1'b1;
          wait_if.load  = wait_load;
          s_nxt.rd_strobe = s_r.rd;
          s_nxt.wr_strobe = !s_r.rd;
          // single buffer stage enabled with the strobe
          s_nxt.xcvr = 1'b1;
          s_nxt.st   = IWT_CMD;
        end
      end
      IWT_CMD: begin
        if (wait_if.done && !wait_if.start) begin
          s_nxt.ready     = 1'b1;
          s_nxt.rd_strobe = 1'b0;
          s_nxt.wr_strobe = 1'b0;
          s_nxt.xcvr      = 1'b0;
          // write recovery only for serial writes
          if (s_r.is_ser && !s_r.rd) s_nxt.ser_space = CNT_W'(WRITE_RECOVERY_CYC);
          if (s_r.is_par) s_nxt.par_space = CNT_W'(ACCESS_SPACING_CYC);
          s_nxt.st = IWT_DONE;
        end
      end
      IWT_DONE: begin
        // hold transceiver off while read data floats
        if (s_r.rd) begin
          wait_if.start = 1'b1;
          wait_if.load  = CNT_W'(READ_FLOAT_CYC);
          s_nxt.st      = IWT_FLOAT;
        end else begin
          // chip selects drop with the return to idle; register selects keep their value
          s_nxt.is_ser = 1'b0;
          s_nxt.is_par = 1'b0;
          s_nxt.st     = IWT_IDLE;
        end
      end
      IWT_FLOAT: begin
        if (wait_if.done && !wait_if.start) begin
          s_nxt.is_ser = 1'b0;
          s_nxt.is_par = 1'b0;
          s_nxt.st     = IWT_IDLE;
        end
      end
      default: begin
        s_nxt.is_ser = 1'b0;
        s_nxt.is_par = 1'b0;
        s_nxt.st     = IWT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= IWT_TOP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ready_out              = s_r.ready;
  assign xcvr_enable_out        = s_r.xcvr;
  assign data_out               = s_r.data;
  assign ser_select_out         = s_r.is_ser;
  assign par_select_out         = s_r.is_par;
  assign register_select_low    = s_r.sel_lo;
  assign register_select_high   = s_r.sel_hi;
  assign io_read_strobe_out     = s_r.rd_strobe;
  assign io_write_strobe_out    = s_r.wr_strobe;
  assign irq_acknowledge_strobe = s_r.ack_out;
  assign ser_clk_out            = s_r.ser_clk;
endmodule : iwt_top
`default_nettype wire

// file: iwt_pkg.sv
`default_nettype none
package iwt_pkg;
  // system clock
  localparam int unsigned CLK_PERIOD_NS = 8;
  // local bus clock the wait states are counted in (8 MHz)
  localparam int unsigned BUS_PERIOD_NS = 125;
  localparam int unsigned BUS_DIV       = BUS_PERIOD_NS / CLK_PERIOD_NS;
  // wait-state and command-delay settings per peripheral
  localparam int unsigned WAIT_STATES_SER = 2;
  localparam int unsigned WAIT_STATES_PAR = 2;
  localparam int unsigned CMD_DELAY_SER   = 0;
  localparam int unsigned CMD_DELAY_PAR   = 0;
  localparam int unsigned CLK_PER_WAIT    = 2;
  // documented times
  localparam int unsigned ACK_DELAY_NS       = 450;
  localparam int unsigned WRITE_RECOVERY_NS  = 300;
  localparam int unsigned ACCESS_SPACING_NS  = 850;
  localparam int unsigned READ_FLOAT_NS      = 120;
  localparam int unsigned READ_STROBE_MIN_NS = 250;
  // derived cycle counts (least times round up)
  localparam int unsigned ACK_DELAY_CYC      = (ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_RECOVERY_CYC = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_SPACING_CYC = (ACCESS_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_FLOAT_CYC     = (READ_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W              = 8;
  // address decode: serial controller is eight byte locations
  localparam int unsigned ADDR_W        = 16;
  localparam logic [15:0] SER_BASE      = 16'h0080;
  localparam logic [15:0] SER_MASK      = 16'hFFF8;
  localparam logic [15:0] PAR_BASE      = 16'h00C0;
  localparam logic [15:0] PAR_MASK      = 16'hFFF8;
  localparam int unsigned SEL_LOW_BIT   = 1;
  localparam int unsigned SEL_HIGH_BIT  = 2;
  // states
  typedef enum logic [5:0] {
    IWT_IDLE  = 6'h01,
    IWT_SPACE = 6'h02,
    IWT_HOLD  = 6'h04,
    IWT_CMD   = 6'h08,
    IWT_DONE  = 6'h10,
    IWT_FLOAT = 6'h20
  } iwt_state_t;
endpackage : iwt_pkg
`default_nettype wire

// file: iwt_cnt_if.sv
`default_nettype none
interface iwt_cnt_if;
  import iwt_pkg::*;
  logic             start;
  logic [CNT_W-1:0] load;
  logic             done;
  modport ctl (output start, output load, input done);
  modport cnt (input start, input load, output done);
endinterface : iwt_cnt_if
`default_nettype wire

// file: iwt_delay.sv
`default_nettype none
module iwt_delay (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // control
  iwt_cnt_if.cnt    ctl
);
  import iwt_pkg::*;
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             done;
  } iwt_dly_t;
  iwt_dly_t s_r;
  iwt_dly_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (ctl.start) begin
      s_nxt.cnt  = ctl.load;
      s_nxt.done = (ctl.load == '0);
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt  = s_r.cnt - CNT_W'(1);
      s_nxt.done = (s_r.cnt == CNT_W'(1));
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '{cnt: '0, done: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign ctl.done = s_r.done;
endmodule : iwt_delay
`default_nettype wire

// file: iwt_top_props.sv
`default_nettype none
module iwt_top_props (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // watched pins
  input wire logic command_holdoff_input,
  input wire logic irq_ack_in,
  input wire logic cascade_mode_in,
  input wire logic ready_out,
  input wire logic xcvr_enable_out,
  input wire logic ser_select_out,
  input wire logic par_select_out,
  input wire logic io_read_strobe_out,
  input wire logic io_write_strobe_out,
  input wire logic irq_acknowledge_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  import iwt_pkg::*;
  logic cmd;
  int   wid_r, wgap_r, pgap_r, rgap_r, ack_r;
  assign cmd = io_read_strobe_out | io_write_strobe_out;
  // gaps start at 1000 so the first access after reset is free
  always_ff @(posedge clk_in) begin
    wid_r  <= cmd ? wid_r + 1 : 0;
    ack_r  <= irq_ack_in ? ack_r + 1 : 0;
    wgap_r <= rst_in ? 1000 : (io_write_strobe_out && ser_select_out) ? 0 : wgap_r + 1;
    pgap_r <= rst_in ? 1000 : (cmd && par_select_out) ? 0 : pgap_r + 1;
    rgap_r <= rst_in ? 1000 : io_read_strobe_out ? 0 : rgap_r + 1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence cmd_rise_s;
    $rose(cmd);
  endsequence
  a_cmd_has_select: assert property (cmd_rise_s |-> ser_select_out ^ par_select_out)
    else $error("command without exactly one select");
  a_strobe_width: assert property ($fell(cmd) |-> wid_r >= WAIT_STATES_SER * CLK_PER_WAIT * BUS_DIV)
    else $error("command shorter than two wait states");
  a_ready_at_end: assert property ($fell(cmd) |-> ##[0:2] ready_out)
    else $error("no ready after command end");
  a_ready_needs_cmd: assert property (ready_out |-> $past(cmd) || $past(cmd, 2))
    else $error("ready without a command");
  a_one_strobe: assert property (io_read_strobe_out |-> !io_write_strobe_out)
    else $error("read and write strobes together");
  a_xcvr_with_cmd: assert property (cmd |-> xcvr_enable_out)
    else $error("transceiver off during command");
  a_write_recovery: assert property ($rose(io_write_strobe_out) && ser_select_out |-> wgap_r >= WRITE_RECOVERY_CYC)
    else $error("serial write recovery too short");
  a_par_spacing: assert property (cmd_rise_s ##0 par_select_out |-> pgap_r >= ACCESS_SPACING_CYC)
    else $error("parallel access spacing too short");
  a_read_float: assert property ($rose(xcvr_enable_out) |-> rgap_r >= READ_FLOAT_CYC)
    else $error("transceiver enabled inside read float time");
  a_ack_delay: assert property ($rose(irq_acknowledge_strobe) && cascade_mode_in |-> ack_r >= ACK_DELAY_CYC)
    else $error("cascaded acknowledge not delayed");
  a_ack_bound: assert property (irq_ack_in && ack_r == 70 |-> irq_acknowledge_strobe)
    else $error("acknowledge strobe never passed on");
  a_holdoff_blocks: assert property ($past(command_holdoff_input, 5) && $past(command_holdoff_input, 6) |-> !$rose(cmd))
    else $error("command issued during holdoff");
endmodule : iwt_top_props
bind iwt_top iwt_top_props u_props (.clk_in, .rst_in, .command_holdoff_input, .irq_ack_in, .cascade_mode_in,
  .ready_out, .xcvr_enable_out, .ser_select_out, .par_select_out, .io_read_strobe_out, .io_write_strobe_out,
  .irq_acknowledge_strobe);
`default_nettype wire

// file: iwt_periph_model.sv
`default_nettype none
module iwt_periph_model (
  // peripheral clock source
  output logic pclk_out,
  // serial controller pins
  input wire logic ser_clk_in,
  input wire logic ack_strobe_in,
  // observation
  output int pclk_rises_out,
  output int ser_rises_out,
  output int acks_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pclk_out = 1'b0;
    pclk_rises_out = 0;
    ser_rises_out = 0;
    acks_out = 0;
  end
  // free running, phase unrelated to the system clock
  always #33 pclk_out = ~pclk_out;
  always @(posedge pclk_out) pclk_rises_out++;
  always @(posedge ser_clk_in) ser_rises_out++;
  always @(posedge ack_strobe_in) acks_out++;
endmodule : iwt_periph_model
`default_nettype wire

// file: iwt_top_bench.sv
`default_nettype none
module iwt_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import iwt_pkg::*;
  logic clk_in = 0, rst_in = 1, start = 0, rd = 0, mem = 0, hold = 0, ack = 0, casc = 0, pclk, was = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, dout;
  logic rdy, xcvr, ssel, psel, rsl, rsh, rds, wrs, acks, sclk;
  logic [4:0] snap;
  int err_total = 0, samples_checked = 0, cyc = 0, t_rise = 0, t_fall = -9999, width, gap, ts, pr, sr, na;
  always #4 clk_in = ~clk_in;
  iwt_top dut (.clk_in, .rst_in, .cycle_start_in(start), .cycle_read_in(rd), .cycle_mem_in(mem),
    .addr_in(addr), .command_holdoff_input(hold), .irq_ack_in(ack), .cascade_mode_in(casc), .pclk_in(pclk),
    .data_in(wdata), .ready_out(rdy), .xcvr_enable_out(xcvr), .data_out(dout), .ser_select_out(ssel),
    .register_select_low(rsl), .register_select_high(rsh), .io_read_strobe_out(rds),
    .io_write_strobe_out(wrs), .irq_acknowledge_strobe(acks), .ser_clk_out(sclk), .par_select_out(psel));
  iwt_periph_model peer (.pclk_out(pclk), .ser_clk_in(sclk), .ack_strobe_in(acks), .pclk_rises_out(pr),
    .ser_rises_out(sr), .acks_out(na));
  // strobe timing seen where outputs have settled
  always @(negedge clk_in) begin
    cyc++;
    if ((rds | wrs) && !was) begin
      gap = cyc - t_fall;
      t_rise = cyc;
      snap = {ssel, psel, rsl, rsh, rds};
    end
    if (!(rds | wrs) && was) begin
      width = cyc - t_rise;
      t_fall = cyc;
    end
    was = rds | wrs;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got, input logic ok);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic go(input logic [15:0] a, input logic r, input logic [7:0] d);
    @(posedge clk_in);
    start <= 1'b1;
    addr <= a;
    rd <= r;
    wdata <= d;
    @(posedge clk_in);
    start <= 1'b0;
    ts = cyc;
  endtask : go
  task automatic wait_rdy;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    @(negedge clk_in);
    chk("ready", 1, rdy, n < 400);
  endtask : wait_rdy
  task automatic run(input logic [15:0] a, input logic r, input logic [7:0] d, input logic p);
    logic [4:0] exp_sel;
    exp_sel = {~p, p, a[SEL_LOW_BIT], a[SEL_HIGH_BIT], r};
    go(a, r, d);
    wait_rdy();
    chk("width", 60, width, width >= 60);
    chk("selects", exp_sel, snap, snap === exp_sel);
    if (!r) chk("data", d, dout, dout === d);
    // a start inside the read float period is dropped
    if (r) repeat (READ_FLOAT_CYC + 2) @(posedge clk_in);
  endtask : run
  task automatic t_serial;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      mem <= i[1];
      run(SER_BASE + 16'(2 * i), i[0], 8'hA5 ^ 8'(i), 1'b0);
      if (i == 0) chk("lag", 6, t_rise - ts, t_rise - ts <= 6);
    end
    // two writes in a row so the recovery gap applies
    for (int k = 0; k < 2; k++) run(SER_BASE + 16'h0002, 1'b0, 8'h3C ^ 8'(k), 1'b0);
    chk("recovery", WRITE_RECOVERY_CYC, gap, gap >= WRITE_RECOVERY_CYC);
  endtask : t_serial
  task automatic t_parallel;
    for (int i = 0; i < 3; i++) begin
      run(PAR_BASE + 16'(2 * i), i < 2, 8'h5A, 1'b1);
      if (i > 0) chk("spacing", ACCESS_SPACING_CYC, gap, gap >= ACCESS_SPACING_CYC);
    end
  endtask : t_parallel
  task automatic t_refuse_hold;
    int r0;
    r0 = t_rise;
    go(16'h0100, 1'b1, 8'h00);
    repeat (150) @(negedge clk_in);
    chk("unmapped", r0, t_rise, t_rise === r0);
    @(posedge clk_in);
    hold <= 1'b1;
    // holdoff must clear its synchroniser before the request
    repeat (6) @(posedge clk_in);
    go(SER_BASE, 1'b1, 8'h00);
    repeat (80) @(negedge clk_in);
    chk("holdoff", r0, t_rise, t_rise === r0);
    @(posedge clk_in);
    hold <= 1'b0;
    wait_rdy();
  endtask : t_refuse_hold
  task automatic t_ack;
    int n;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_in);
      casc <= m[0];
      @(posedge clk_in);
      ack <= 1'b1;
      n = 0;
      while (acks !== 1'b1 && n < 200) begin
        @(negedge clk_in);
        n++;
      end
      chk("ack delay", ACK_DELAY_CYC, n, m ? n >= ACK_DELAY_CYC && n < 70 : n <= 8);
      chk("ack seen", m + 1, na, na == m + 1);
      repeat (80) @(posedge clk_in);
      ack <= 1'b0;
      repeat (20) @(posedge clk_in);
    end
  endtask : t_ack
  task automatic t_clk;
    int p0, s0;
    p0 = pr;
    s0 = sr;
    repeat (400) @(negedge clk_in);
    chk("clock div", (pr - p0) / 2, sr - s0, (pr - p0) - 2 * (sr - s0) inside {[-2:2]});
  endtask : t_clk
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    t_serial();
    t_parallel();
    t_refuse_hold();
    t_ack();
    t_clk();
    end_of_test();
  end
  // cut a hang well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    end_of_test();
  end
endmodule : iwt_top_bench
`default_nettype wire
